/* File: hdl/exc_pkg.sv */
// constants for the reset-cause register and the interrupt priority logic
// assumes one APB bus clock; all offsets are byte addresses of 32-bit words
`default_nettype none
package exc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CAUSE   = 8'h00;
    localparam logic [7:0] OFS_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_FLAGS   = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;

    // reset-cause bit positions
    localparam int CB_LOWV    = 1;
    localparam int CB_MONITOR = 2;
    localparam int CB_BADADR  = 3;
    localparam int CB_BADOP   = 4;
    localparam int CB_WDOG    = 5;
    localparam int CB_EXT     = 6;
    localparam int CB_POR     = 7;
    localparam logic [7:0] CAUSE_POR_VAL = 8'h82;

    // latched source bits, shared by enable and flag registers
    localparam int SB_IRQ   = 0;
    localparam int SB_LOCK  = 1;
    localparam int SB_T1C0  = 2;
    localparam int SB_T1C1  = 3;
    localparam int SB_T1W   = 4;
    localparam int SB_T2C0  = 5;
    localparam int SB_T2C1  = 6;
    localparam int SB_T2W   = 7;
    localparam logic [7:0] ENABLE_RST = 8'h00;

    // status register layout
    localparam int ST_BUSY = 16;

    // vectors
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_SWI   = 16'hFFFC;
    localparam logic [15:0] VEC_LVL1  = 16'hFFFA;

    typedef enum logic {ST_IDLE, ST_ENTRY} entry_e;

endpackage
`default_nettype wire

/* File: hdl/reset_cause_and_irq_priority.sv */
// reset-cause status register and interrupt priority/entry sequencer
// assumes a CPU core that pulses at instruction boundaries and acks stacking
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_irq_priority
    import exc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        por_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rst_pin_n,
    input  wire logic        wdog_reset,
    input  wire logic        bad_opcode_reset,
    input  wire logic        bad_fetch_reset,
    input  wire logic        monitor_reset,
    input  wire logic        low_voltage_reset,
    input  wire logic        irq_pin_n,
    input  wire logic        pll_locked,
    input  wire logic        t1_ch0_event,
    input  wire logic        t1_ch1_event,
    input  wire logic        t1_wrap,
    input  wire logic        t2_ch0_event,
    input  wire logic        t2_ch1_event,
    input  wire logic        t2_wrap,
    input  wire logic [7:0]  other_req,
    input  wire logic        insn_done,
    input  wire logic        rti_done,
    input  wire logic        i_mask,
    input  wire logic        swi_exec,
    input  wire logic        break_hit,
    input  wire logic        entry_done,
    output logic             int_take,
    output logic [15:0]      int_vector,
    output logic             stack_pc_minus1,
    output logic             set_i_mask,
    output logic             push_index_high,
    output logic             entry_busy
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [3:0] top_level(input logic [15:0] req);
        logic [3:0] idx;
        idx = 4'hF;
        for (int i = 15; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] level_vector(input logic [3:0] idx);
        return VEC_LVL1 - {11'h000, idx, 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [1:0] rstpin_sync_r;
    logic [1:0] irqpin_sync_r;
    logic [1:0] lock_sync_r;
    logic       lock_prev_r;

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            rstpin_sync_r <= 2'b11;
        end else begin
            rstpin_sync_r <= {rstpin_sync_r[0], rst_pin_n};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqpin_sync_r <= 2'b11;
            lock_sync_r   <= 2'b00;
            lock_prev_r   <= 1'b0;
        end else begin
            irqpin_sync_r <= {irqpin_sync_r[0], irq_pin_n};
            lock_sync_r   <= {lock_sync_r[0], pll_locked};
            lock_prev_r   <= lock_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    logic        apb_setup;
    logic        apb_fire;
    logic        rd_cause_fire;
    logic        wr_enable_fire;
    logic        wr_flags_fire;
    logic        addr_ok;
    logic [31:0] rd_mux;
    logic [7:0]  cause_r;
    logic [7:0]  enable_r;
    logic [7:0]  flag_r;
    logic [15:0] req_lvl;
    entry_e      state_r;

    assign apb_setup      = psel && !penable;
    assign apb_fire       = psel && penable && pready;
    assign rd_cause_fire  = apb_fire && !pwrite && (paddr == OFS_CAUSE);
    assign wr_enable_fire = apb_fire && pwrite && (paddr == OFS_ENABLE);
    assign wr_flags_fire  = apb_fire && pwrite && (paddr == OFS_FLAGS);
    assign addr_ok        = (paddr == OFS_CAUSE) || (paddr == OFS_ENABLE)
                          || (paddr == OFS_FLAGS) || (paddr == OFS_STATUS);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_CAUSE:  rd_mux = {24'h000000, cause_r};
            OFS_ENABLE: rd_mux = {24'h000000, enable_r};
            OFS_FLAGS:  rd_mux = {24'h000000, flag_r};
            OFS_STATUS: begin
                rd_mux[15:0]    = req_lvl;
                rd_mux[ST_BUSY] = (state_r == ST_ENTRY);
            end
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // answer one cycle after setup: access phase always has pready high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (apb_setup) begin
            pready  <= 1'b1;
            pslverr <= !addr_ok;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        end else if (apb_fire) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset-cause register, kept across system reset, loaded with CAUSE_POR_VAL only by power-on, cleared bit by bit by reads

    logic [7:0] cause_set;

    always_comb begin
        cause_set             = 8'h00;
        cause_set[CB_EXT]     = !rstpin_sync_r[1];
        cause_set[CB_WDOG]    = wdog_reset;
        cause_set[CB_BADOP]   = bad_opcode_reset;
        cause_set[CB_BADADR]  = bad_fetch_reset;
        cause_set[CB_MONITOR] = monitor_reset;
        cause_set[CB_LOWV]    = low_voltage_reset;
    end

    // read clears only the bits it handed out: a cause landing after the
    // setup-edge capture would otherwise vanish unseen
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            cause_r <= CAUSE_POR_VAL;
        end else if (rd_cause_fire) begin
            cause_r <= (cause_r & ~prdata[7:0]) | cause_set;
        end else begin
            cause_r <= cause_r | cause_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source flags and enables

    logic       serve_irq;
    logic [7:0] flag_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= ENABLE_RST;
        end else if (wr_enable_fire) begin
            enable_r <= pwdata[7:0];
        end
    end

    always_comb begin
        flag_set          = 8'h00;
        flag_set[SB_IRQ]  = !irqpin_sync_r[1];
        flag_set[SB_LOCK] = lock_sync_r[1] != lock_prev_r;
        flag_set[SB_T1C0] = t1_ch0_event;
        flag_set[SB_T1C1] = t1_ch1_event;
        flag_set[SB_T1W]  = t1_wrap;
        flag_set[SB_T2C0] = t2_ch0_event;
        flag_set[SB_T2C1] = t2_ch1_event;
        flag_set[SB_T2W]  = t2_wrap;
    end

    // pin latch clears on service; peripheral flags by write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 8'h00;
        end else begin
            flag_r[SB_IRQ] <= flag_set[SB_IRQ] || (flag_r[SB_IRQ] && !serve_irq);
            for (int i = SB_LOCK; i <= SB_T2W; i++) begin
                flag_r[i] <= flag_set[i]
                          || (flag_r[i] && !(wr_flags_fire && pwdata[i]));
            end
        end
    end

    // levels 1..8 from gated flags, 9..16 already merged by their modules
    assign req_lvl = {other_req, flag_r & enable_r};

    ////////////////////////////////////////////////////////////////////////
    // entry sequencer

    logic        boundary;
    logic        swi_pend_r;
    logic        take_swi;
    logic        take_hw;
    logic [3:0]  win_idx;

    assign boundary  = insn_done || rti_done;
    assign win_idx   = top_level(req_lvl);
    assign take_swi  = (state_r == ST_IDLE) && boundary && swi_pend_r;
    assign take_hw   = (state_r == ST_IDLE) && boundary && !swi_pend_r
                     && !i_mask && (req_lvl != 16'h0000);
    assign serve_irq = take_hw && (win_idx == 4'h0);

    // break point turns into a pending software interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swi_pend_r <= 1'b0;
        end else begin
            swi_pend_r <= swi_exec || break_hit || (swi_pend_r && !take_swi);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE:  if (take_swi || take_hw) state_r <= ST_ENTRY;
                ST_ENTRY: if (entry_done) state_r <= ST_IDLE;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    // vector and stacking controls frozen while entry is under way
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_take        <= 1'b0;
            set_i_mask      <= 1'b0;
            int_vector      <= VEC_RESET;
            stack_pc_minus1 <= 1'b0;
            push_index_high <= 1'b0;
            entry_busy      <= 1'b0;
        end else begin
            int_take        <= take_swi || take_hw;
            set_i_mask      <= take_swi || take_hw;
            push_index_high <= 1'b0;
            entry_busy      <= (take_swi || take_hw)
                            || (entry_busy && !entry_done);
            if (take_swi) begin
                int_vector      <= VEC_SWI;
                stack_pc_minus1 <= 1'b0;
            end else if (take_hw) begin
                int_vector      <= level_vector(win_idx);
                stack_pc_minus1 <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ext_flag_set: assert property (!rstpin_sync_r[1] |=> cause_r[CB_EXT])
        else $error("external reset flag not set");
    a_wdog_flag_set: assert property (wdog_reset |=> cause_r[CB_WDOG])
        else $error("watchdog flag not set");
    a_badop_flag_set: assert property (bad_opcode_reset |=> cause_r[CB_BADOP])
        else $error("bad opcode flag not set");
    a_badadr_flag_set: assert property (bad_fetch_reset |=> cause_r[CB_BADADR])
        else $error("bad fetch flag not set");
    a_monitor_flag_set: assert property (monitor_reset |=> cause_r[CB_MONITOR])
        else $error("monitor entry flag not set");
    a_lowv_flag_set: assert property (low_voltage_reset |=> cause_r[CB_LOWV])
        else $error("low voltage flag not set");
    a_cause_read_clear: assert property (disable iff (!por_n)
        (rd_cause_fire && cause_set == 8'h00 && cause_r == prdata[7:0]) |=> cause_r == 8'h00)
        else $error("cause register not cleared by read");
    a_cause_kept: assert property (disable iff (!por_n)
        (rd_cause_fire && cause_r != prdata[7:0]) |=> cause_r != 8'h00)
        else $error("cause arriving during read was lost");
    a_take_at_boundary: assert property ($rose(entry_busy) |-> $past(boundary))
        else $error("entry started off an instruction boundary");
    a_take_sets_mask: assert property (int_take |-> set_i_mask && entry_busy)
        else $error("entry without mask set");
    a_no_preempt: assert property ((entry_busy && !entry_done) |=> $stable(int_vector))
        else $error("vector changed during entry");
    a_highest_wins: assert property (take_hw |=> int_vector == level_vector($past(win_idx)))
        else $error("wrong priority vector");
    a_swi_unmasked: assert property (take_swi |=> int_take && int_vector == VEC_SWI)
        else $error("software interrupt not taken");
    a_pc_adjust: assert property (int_take |-> stack_pc_minus1 == (int_vector != VEC_SWI))
        else $error("wrong stacked pc adjust");
    a_no_index_high: assert property (push_index_high == 1'b0)
        else $error("index high byte stacked");
    a_lock_edge_flag: assert property ((lock_sync_r[1] != lock_prev_r) |=> flag_r[SB_LOCK])
        else $error("lock change flag not set");
    a_timer_wrap_flag: assert property (t1_wrap |=> flag_r[SB_T1W])
        else $error("timer wrap flag not set");
    a_channel_flag: assert property (t2_ch1_event |=> flag_r[SB_T2C1])
        else $error("channel flag not set");
    a_apb_one_wait: assert property (apb_setup |=> pready) // apb answer timing
        else $error("apb answer late");
    // independent of the priority function: no lower level may be set
    a_lowest_level: assert property (take_hw |-> req_lvl[win_idx]
        && ((req_lvl & ((16'h0001 << win_idx) - 16'h0001)) == 16'h0000))
        else $error("lower level request skipped");
    a_mask_blocks_hw: assert property ((i_mask && !swi_pend_r) |=> !int_take)
        else $error("masked request taken");
    a_busy_no_take: assert property (entry_busy |=> !int_take)
        else $error("entry started while busy");
    a_entry_ends: assert property ((entry_busy && entry_done) |=> !entry_busy)
        else $error("entry busy held after done");
    a_irq_latched: assert property ((flag_r[SB_IRQ] && !serve_irq) |=> flag_r[SB_IRQ])
        else $error("pin request dropped before service");
    a_break_pends: assert property (break_hit |=> swi_pend_r)
        else $error("break point not turned into software interrupt");
    a_rti_serves: assert property ((rti_done && !entry_busy && !i_mask
        && req_lvl != 16'h0000) |=> int_take)
        else $error("pending request not taken at return");

    c_swi_taken: cover property (take_swi && i_mask);
    c_hw_taken: cover property (take_hw && req_lvl[SB_IRQ]);
    c_rti_chain: cover property (rti_done && take_hw);
    c_cause_read: cover property (rd_cause_fire && cause_r[CB_POR]);
    c_busy_refused: cover property (entry_busy && insn_done);

endmodule
`default_nettype wire

/* File: sim/cpu_core_model.sv */
// behavioural cpu core facing the interrupt sequencer
// assumes one-cycle int_take and set_i_mask pulses from the sequencer
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       int_take,
    input  wire logic       set_i_mask,
    input  wire logic       rti_req,
    input  wire logic [4:0] ack_delay,
    output logic            insn_done,
    output logic            rti_done,
    output logic            i_mask,
    output logic            entry_done
);
    logic [1:0] phase_r;
    logic [5:0] ack_r;
    ////////////////////////////////////////////////////////////////////////////
    // boundary every fourth cycle, even while stacking, so refusals get exercised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r   <= 2'h0;
            insn_done <= 1'b0;
        end else begin
            phase_r   <= phase_r + 2'h1;
            insn_done <= (phase_r == 2'h3);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // stacking ack after a chosen delay: prompt or slow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r      <= 6'h00;
            entry_done <= 1'b0;
        end else begin
            entry_done <= (ack_r == 6'h01);
            if (int_take)
                ack_r <= {1'b0, ack_delay} + 6'h01;
            else if (ack_r != 6'h00)
                ack_r <= ack_r - 6'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // mask bit: set by entry, cleared by return, which is also a boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i_mask   <= 1'b0;
            rti_done <= 1'b0;
        end else begin
            rti_done <= rti_req;
            if (rti_req)
                i_mask <= 1'b0;
            else if (set_i_mask)
                i_mask <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/reset_cause_and_irq_priority_tb.sv */
// self-checking bench: reset-cause register and interrupt sequencer
// assumes cpu_core_model as partner and an APB master built from tasks
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_irq_priority_tb;
    import exc_pkg::*;
    logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err;
    logic        rst_pin_n, irq_pin_n, pll_locked, swi_exec, break_hit, rti_req;
    logic        insn_done, rti_done, i_mask, entry_done, int_take, entry_busy;
    logic        stack_pc_minus1, set_i_mask, push_index_high, bnd_p, rti_p, last_rti;
    logic [7:0]  paddr, other_req;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  csrc, ack_delay;
    logic [5:0]  tevt;
    logic [15:0] int_vector;
    logic [18:0] last_take;
    int          fail_count, tests_run, takes_n, taken_chk, cyc, bad_bnd;
    int          cb [5] = '{CB_WDOG, CB_BADOP, CB_BADADR, CB_MONITOR, CB_LOWV};

    reset_cause_and_irq_priority dut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rst_pin_n, .wdog_reset(csrc[0]),
        .bad_opcode_reset(csrc[1]), .bad_fetch_reset(csrc[2]), .monitor_reset(csrc[3]),
        .low_voltage_reset(csrc[4]), .irq_pin_n, .pll_locked, .t1_ch0_event(tevt[0]),
        .t1_ch1_event(tevt[1]), .t1_wrap(tevt[2]), .t2_ch0_event(tevt[3]),
        .t2_ch1_event(tevt[4]), .t2_wrap(tevt[5]), .other_req, .insn_done, .rti_done,
        .i_mask, .swi_exec, .break_hit, .entry_done, .int_take, .int_vector,
        .stack_pc_minus1, .set_i_mask, .push_index_high, .entry_busy);
    cpu_core_model cpu (.pclk, .presetn, .int_take, .set_i_mask, .rti_req, .ack_delay,
        .insn_done, .rti_done, .i_mask, .entry_done);
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // cut a hang short; run needs about 400 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    // every entry recorded; entry must follow a boundary cycle
    always @(posedge pclk) begin
        if (int_take === 1'b1) begin
            takes_n++;
            last_take = {push_index_high, set_i_mask, stack_pc_minus1, int_vector};
            last_rti  = rti_p;
            if (bnd_p !== 1'b1)
                bad_bnd++;
        end
        bnd_p = insn_done | rti_done;
        rti_p = rti_done;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_take(input logic [18:0] exp);
        while (takes_n == taken_chk) begin
            @(posedge pclk);
        end
        taken_chk++;
        chk({13'h0, last_take}, {13'h0, exp});
        chk({31'h0, entry_busy}, 32'h1);
    endtask
    task automatic ret_int;
        rti_req <= 1'b1;
        @(posedge pclk);
        rti_req <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, por_n, psel, penable, pwrite, rti_req, swi_exec, break_hit} = '0;
        {rst_pin_n, irq_pin_n, pll_locked} = 3'b110;
        paddr = 8'h00;
        pwdata = 32'h0;
        {csrc, tevt, other_req} = '0;
        ack_delay = 5'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_CAUSE, 32'h0);
        chk(rd, {24'h0, CAUSE_POR_VAL});
        for (int i = 0; i < 5; i++) begin
            csrc <= 5'h01 << i;
            @(posedge pclk);
            csrc <= 5'h00;
            apb(1'b0, OFS_CAUSE, 32'h0);
            chk(rd, 32'h1 << cb[i]);
            apb(1'b0, OFS_CAUSE, 32'h0);
            chk(rd, 32'h0);
        end
        rst_pin_n <= 1'b0;
        repeat (3) @(posedge pclk);
        rst_pin_n <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_CAUSE, 32'h0);
        chk(rd, 32'h1 << CB_EXT);
        // cause lands on the setup edge of a read: must survive it
        csrc <= 5'h01;
        fork
            apb(1'b0, OFS_CAUSE, 32'h0);
            begin
                @(posedge pclk);
                csrc <= 5'h00;
            end
        join
        chk(rd, 32'h0);
        apb(1'b0, OFS_CAUSE, 32'h0);
        chk(rd, 32'h1 << CB_WDOG);
        apb(1'b0, OFS_ENABLE, 32'h0);
        chk(rd, {24'h0, ENABLE_RST});
        apb(1'b1, OFS_ENABLE, 32'hFF);
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        // each timer source alone, prompt ack
        for (int i = 0; i < 6; i++) begin
            tevt <= 6'h01 << i;
            @(posedge pclk);
            tevt <= 6'h00;
            wait_take({3'b011, VEC_LVL1 - 16'(4 + 2 * i)});
            apb(1'b1, OFS_FLAGS, 32'h1 << (SB_T1C0 + i));
            ret_int();
        end
        // two pending, slow ack, pin request arrives during stacking
        ack_delay <= 5'h14;
        tevt <= 6'h21;
        @(posedge pclk);
        tevt <= 6'h00;
        wait_take({3'b011, VEC_LVL1 - 16'h0004});
        irq_pin_n <= 1'b0;
        repeat (2) @(posedge pclk);
        irq_pin_n <= 1'b1;
        repeat (30) @(posedge pclk);
        chk(takes_n, taken_chk);
        chk({31'h0, entry_busy}, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h85);
        apb(1'b1, OFS_FLAGS, 32'h1 << SB_T1C0);
        swi_exec <= 1'b1;
        @(posedge pclk);
        swi_exec <= 1'b0;
        wait_take({3'b010, VEC_SWI});
        repeat (25) @(posedge pclk);
        ret_int();
        wait_take({3'b011, VEC_LVL1});
        repeat (25) @(posedge pclk);
        ret_int();
        wait_take({3'b011, VEC_LVL1 - 16'h000E});
        chk({31'h0, last_rti}, 32'h1);
        apb(1'b1, OFS_FLAGS, 32'h1 << SB_T2W);
        repeat (25) @(posedge pclk);
        ret_int();
        repeat (20) @(posedge pclk);
        chk(takes_n, taken_chk);
        // lock change with its enable off, then on
        apb(1'b1, OFS_ENABLE, 32'hFD);
        pll_locked <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk(rd, 32'h1 << SB_LOCK);
        apb(1'b1, OFS_ENABLE, 32'hFF);
        wait_take({3'b011, VEC_LVL1 - 16'h0002});
        apb(1'b1, OFS_FLAGS, 32'h1 << SB_LOCK);
        break_hit <= 1'b1;
        @(posedge pclk);
        break_hit <= 1'b0;
        wait_take({3'b010, VEC_SWI});
        other_req <= 8'h01;
        repeat (25) @(posedge pclk);
        ret_int();
        wait_take({3'b011, VEC_LVL1 - 16'h0010});
        other_req <= 8'h00;
        chk(bad_bnd, 0);
        end_of_test();
    end
endmodule
`default_nettype wire
